// File: design/flag_host_consts.svh
/*
 file: timing counts and field layout for the flag-space host controller.
 assumes: included by the package and the host module, 40 MHz core_clk.
*/
// Functional notes
// - flags reached with select low, normal strobes
// - poller drops select or enable between reads
// - claim by writing zero, then reading back
// - after failure, reread or write one to withdraw
// - start-up writes one to every flag
`ifndef FLAG_HOST_CONSTS_SVH
`define FLAG_HOST_CONSTS_SVH
`define CLK_PERIOD_NS      25
`define ACCESS_TIME_NS     55
`define ACCESS_CYCLES      ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_TIME_NS        25
`define GAP_CYCLES         ((`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// read strobe outlasts the four-cycle sync lag (three flops plus output register) by one cycle
`define READ_CYCLES        (`ACCESS_CYCLES + 1)
`define IDX_W              3
`define DATA_W             16
`define ADDR_W             15
`define FLAG_COUNT         8
`define CNT_W              4
`endif

// File: design/flag_host_pkg.sv
/*
 file: types shared by the flag-space host controller.
 assumes: consts header on the include path.
*/
`include "flag_host_consts.svh"
package flag_host_pkg;
   typedef enum logic [1:0]
   {
      OP_CLAIM   = 2'h0,
      OP_RELEASE = 2'h1,
      OP_READ    = 2'h2,
      OP_INIT    = 2'h3
   } op_e;

   typedef struct packed
   {
      op_e                  op;
      logic [`IDX_W-1:0]    idx;
   } cmd_s;

   typedef struct packed
   {
      logic                 flag;
      logic                 granted;
      logic [`IDX_W-1:0]    idx;
   } result_s;

   typedef struct packed
   {
      logic                 sel_n;
      logic                 oe_n;
      logic                 wr_n;
      logic [`ADDR_W-1:0]   addr;
   } pins_s;
endpackage

// File: design/flag_pin_sync.sv
/*
 file: three-stage synchroniser for the device data inputs.
 assumes: data arrive asynchronous to core_clk.
*/
`timescale 1ns/100ps
`include "flag_host_consts.svh"
module flag_pin_sync
   import flag_host_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic [`DATA_W-1:0]   din,
   output logic      [`DATA_W-1:0]   dout
);
   logic [`DATA_W-1:0] s1_r;
   logic [`DATA_W-1:0] s2_r;
   logic [`DATA_W-1:0] s3_r;
   logic [`DATA_W-1:0] dout_r;
   logic [`DATA_W-1:0] dout_nxt;

   always_comb
   begin
      dout_nxt = dout_r;
      if (s2_r == s3_r)
      begin
         dout_nxt = s3_r;
      end
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         dout_r <= '0;
      end
      else
      begin
         s1_r   <= din;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;
endmodule

// File: design/flag_host.sv
/*
 file: host controller driving one port of a dual-port flag space.
 assumes: one port's pins; the far port is driven by another party.
*/
`timescale 1ns/100ps
`include "flag_host_consts.svh"
module flag_host
   import flag_host_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic                 cmd_valid,
   input  wire cmd_s                 cmd,
   output logic                      cmd_ready,
   output logic                      res_valid,
   output result_s                   res,
   output pins_s                     pins,
   input  wire logic [`DATA_W-1:0]   data_in,
   output logic      [`DATA_W-1:0]   data_out,
   output logic                      data_oe
);
   typedef enum logic [5:0]
   {
      ST_IDLE  = 6'h01,
      ST_WRITE = 6'h02,
      ST_GAP1  = 6'h04,
      ST_READ  = 6'h08,
      ST_GAP2  = 6'h10,
      ST_DONE  = 6'h20
   } state_e;

   state_e               st_r, st_nxt;
   cmd_s                 cmd_r, cmd_nxt;
   logic [`CNT_W-1:0]    cnt_r, cnt_nxt;
   logic [`IDX_W-1:0]    init_r, init_nxt;
   result_s              res_r, res_nxt;
   pins_s                pins_r, pins_nxt;
   logic [`DATA_W-1:0]   dout_r, dout_nxt;
   logic                 oe_r, oe_nxt;
   logic [`DATA_W-1:0]   din_sync;

   flag_pin_sync u_sync
   (
      .core_clk (core_clk),
      .reset    (reset),
      .din      (data_in),
      .dout     (din_sync)
   );

   // flag address: index in low bits, rest zero
   function automatic logic [`ADDR_W-1:0] flag_addr(input logic [`IDX_W-1:0] i);
      flag_addr = {{(`ADDR_W-`IDX_W){1'b0}}, i};
   endfunction

   function automatic logic [`DATA_W-1:0] flag_word(input logic b);
      flag_word = {{(`DATA_W-1){1'b0}}, b};
   endfunction

   // one step down of the strobe counter
   function automatic logic [`CNT_W-1:0] cnt_dec(input logic [`CNT_W-1:0] c);
      cnt_dec = c - `CNT_W'(1);
   endfunction

   // strobe or gap ends on this cycle
   function automatic logic cnt_last(input logic [`CNT_W-1:0] c);
      cnt_last = (c == `CNT_W'(1));
   endfunction

   // next flag of the start-up sweep
   function automatic logic [`IDX_W-1:0] idx_next(input logic [`IDX_W-1:0] i);
      idx_next = i + `IDX_W'(1);
   endfunction

   always_comb
   begin
      st_nxt   = st_r;
      cmd_nxt  = cmd_r;
      cnt_nxt  = cnt_r;
      init_nxt = init_r;
      res_nxt  = res_r;
      pins_nxt = pins_r;
      dout_nxt = dout_r;
      oe_nxt   = oe_r;
      case (st_r)
         ST_IDLE:
         begin
            if (cmd_valid)
            begin
               cmd_nxt       = cmd;
               init_nxt      = '0;
               pins_nxt.addr = flag_addr(cmd.idx);
               cnt_nxt       = `CNT_W'(`ACCESS_CYCLES);
               if (cmd.op == OP_READ)
               begin
                  pins_nxt.sel_n = 1'b0;
                  pins_nxt.oe_n  = 1'b0;
                  cnt_nxt        = `CNT_W'(`READ_CYCLES);
                  st_nxt         = ST_READ;
               end
               else
               begin
                  // claim writes zero first, never reads first
                  // a one write also withdraws a failed request
                  dout_nxt = flag_word(cmd.op == OP_CLAIM ? 1'b0 : 1'b1);
                  if (cmd.op == OP_INIT)
                  begin
                     pins_nxt.addr = flag_addr('0);
                  end
                  oe_nxt         = 1'b1;
                  pins_nxt.sel_n = 1'b0;
                  pins_nxt.wr_n  = 1'b0;
                  st_nxt         = ST_WRITE;
               end
            end
         end
         ST_WRITE:
         begin
            cnt_nxt = cnt_dec(cnt_r);
            if (cnt_last(cnt_r))
            begin
               pins_nxt.sel_n = 1'b1;
               pins_nxt.wr_n  = 1'b1;
               oe_nxt         = 1'b0;
               cnt_nxt        = `CNT_W'(`GAP_CYCLES);
               st_nxt         = ST_GAP1;
            end
         end
         ST_GAP1:
         begin
            cnt_nxt = cnt_dec(cnt_r);
            if (cnt_last(cnt_r))
            begin
               cnt_nxt = `CNT_W'(`ACCESS_CYCLES);
               if (cmd_r.op == OP_INIT && init_r != `IDX_W'(`FLAG_COUNT-1))
               begin
                  init_nxt       = idx_next(init_r);
                  pins_nxt.addr  = flag_addr(idx_next(init_r));
                  pins_nxt.sel_n = 1'b0;
                  pins_nxt.wr_n  = 1'b0;
                  oe_nxt         = 1'b1;
                  st_nxt         = ST_WRITE;
               end
               else if (cmd_r.op == OP_CLAIM)
               begin
                  pins_nxt.sel_n = 1'b0; // read back after write
                  pins_nxt.oe_n  = 1'b0;
                  cnt_nxt        = `CNT_W'(`READ_CYCLES);
                  st_nxt         = ST_READ;
               end
               else
               begin
                  // write-only commands report the value written
                  res_nxt.flag    = 1'b1;
                  res_nxt.granted = 1'b0;
                  res_nxt.idx     = cmd_r.idx;
                  st_nxt  = ST_DONE;
               end
            end
         end
         ST_READ:
         begin
            // sample only once the synchronised word has settled
            cnt_nxt = cnt_dec(cnt_r);
            if (cnt_r == `CNT_W'(0))
            begin
               // all bits carry the flag; bit zero is enough
               res_nxt.flag    = din_sync[0];
               res_nxt.granted = (cmd_r.op == OP_CLAIM) && !din_sync[0];
               res_nxt.idx     = cmd_r.idx;
               pins_nxt.sel_n  = 1'b1; // drop select between reads
               pins_nxt.oe_n   = 1'b1;
               cnt_nxt         = `CNT_W'(`GAP_CYCLES);
               st_nxt          = ST_GAP2;
            end
         end
         ST_GAP2:
         begin
            cnt_nxt = cnt_dec(cnt_r);
            if (cnt_last(cnt_r))
            begin
               st_nxt = ST_DONE;
            end
         end
         ST_DONE:
         begin
            st_nxt = ST_IDLE;
         end
         default:
         begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st_r   <= ST_IDLE;
         cmd_r  <= '0;
         cnt_r  <= '0;
         init_r <= '0;
         res_r  <= '0;
         pins_r <= '{sel_n: 1'b1, oe_n: 1'b1, wr_n: 1'b1, addr: '0};
         dout_r <= '0;
         oe_r   <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         cmd_r  <= cmd_nxt;
         cnt_r  <= cnt_nxt;
         init_r <= init_nxt;
         res_r  <= res_nxt;
         pins_r <= pins_nxt;
         dout_r <= dout_nxt;
         oe_r   <= oe_nxt;
      end
   end

   assign cmd_ready = (st_r == ST_IDLE);
   assign res_valid = (st_r == ST_DONE);
   assign res       = res_r;
   assign pins      = pins_r;
   assign data_out  = dout_r;
   assign data_oe   = oe_r;
endmodule

// File: tb/flag_host_properties.sv
/*
 checker on the ports of flag_host, bound to every instance.
 assumes: core_clk domain, reset async active high.
*/
`timescale 1ns/100ps
`include "flag_host_consts.svh"
module flag_host_properties
   import flag_host_pkg::*;
(
   input wire logic                 core_clk,
   input wire logic                 reset,
   input wire logic                 cmd_valid,
   input wire cmd_s                 cmd,
   input wire logic                 cmd_ready,
   input wire logic                 res_valid,
   input wire result_s              res,
   input wire pins_s                pins,
   input wire logic [`DATA_W-1:0]   data_in,
   input wire logic [`DATA_W-1:0]   data_out,
   input wire logic                 data_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic tk = cmd_valid && cmd_ready;
   AST_TAKE_BUSY: assert property (tk |=> !cmd_ready)
      else $error("ready after take");
   AST_RES_PULSE: assert property (res_valid |=> !res_valid)
      else $error("result pulse too long");
   AST_REL_WRITE: assert property (tk && cmd.op == OP_RELEASE |=>
      !pins.sel_n && !pins.wr_n && data_oe && data_out == 16'h0001)
      else $error("release not a one write");
   AST_CLAIM_WRITE: assert property (tk && cmd.op == OP_CLAIM |=>
      !pins.sel_n && !pins.wr_n && data_oe && data_out == 16'h0000)
      else $error("claim not a zero write");
   AST_INDEX: assert property (tk && cmd.op != OP_INIT |=>
      pins.addr[2:0] == $past(cmd.idx))
      else $error("wrong flag index");
   AST_HOLD: assert property ($fell(pins.sel_n) |-> !pins.sel_n [*3])
      else $error("strobe too short");
   AST_READ_HOLD: assert property ($fell(pins.oe_n) |-> !pins.sel_n [*5])
      else $error("read strobe too short");
   AST_READ_NO_DRIVE: assert property (!pins.oe_n |-> !data_oe && pins.wr_n)
      else $error("drive during read");
   AST_GAP: assert property ($rose(pins.sel_n) |-> pins.oe_n && pins.wr_n)
      else $error("strobes not dropped");
   AST_REL_DONE: assert property (tk && cmd.op == OP_RELEASE |->
      ##[5:6] res_valid && res.flag)
      else $error("release result late");
   cover property (tk && cmd.op == OP_CLAIM);
   cover property (res_valid && res.granted);
   cover property (!pins.oe_n);
   cover property (tk && cmd.op == OP_INIT);
endmodule
bind flag_host flag_host_properties chk (.*);

// File: tb/flag_sem_model.sv
/*
 behavioural flag space with two ports.
 assumes: host on the left pins, bench on the right.
*/
`timescale 1ns/100ps
module flag_sem_model
   import flag_host_pkg::*;
(
   input wire pins_s         lp,
   input wire pins_s         rp,
   input wire logic [15:0]   ld,
   input wire logic [15:0]   rd,
   output logic [15:0]       lq,
   output logic [15:0]       rq
);
   logic [7:0] rql = 8'h00, rqr = 8'h00; // both start at 8'h00
   logic [1:0] own [8] = '{default: 2'h0}; // 1 left, 2 right
   logic       lf = 1'b1, rf = 1'b1;
   function void upd(input logic [2:0] i);
      if (own[i] == 2'h1 && rql[i]) own[i] = 2'h0;
      if (own[i] == 2'h2 && rqr[i]) own[i] = 2'h0;
      if (own[i] == 2'h0) own[i] = !rql[i] ? 2'h1 : !rqr[i] ? 2'h2 : 2'h0;
   endfunction
   always @(negedge (lp.sel_n | lp.wr_n)) #1
   begin
      rql[lp.addr[2:0]] = ld[0];
      upd(lp.addr[2:0]);
   end
   always @(negedge (rp.sel_n | rp.wr_n)) #1
   begin
      rqr[rp.addr[2:0]] = rd[0];
      upd(rp.addr[2:0]);
   end
   always @(negedge (lp.sel_n | lp.oe_n)) #1 lf = own[lp.addr[2:0]] != 2'h1;
   always @(negedge (rp.sel_n | rp.oe_n)) #1 rf = own[rp.addr[2:0]] != 2'h2;
   assign lq = {16{(lp.sel_n | lp.oe_n) ^ lf}};
   assign rq = {16{(rp.sel_n | rp.oe_n) ^ rf}};
endmodule

// File: tb/test_dual_port_semaphore_flags.sv
/*
 bench: host on left port, far processor driven here on right.
 assumes: 40 MHz core_clk, inputs change at falling edge.
*/
`timescale 1ns/100ps
module test_dual_port_semaphore_flags
   import flag_host_pkg::*;
;
   logic        core_clk = 0, reset = 1, cmd_valid = 0, cmd_ready, res_valid, data_oe;
   cmd_s        cmd = '0;
   result_s     res;
   pins_s       pins, rp = '1;
   logic [15:0] data_in, data_out, rd = '0, rq;
   int          error_cnt = 0, checks = 0;
   always #12.5 core_clk = ~core_clk;
   flag_host dut (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .res_valid(res_valid), .res(res), .pins(pins),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
   flag_sem_model mdl (.lp(pins), .rp(rp), .ld(data_out), .rd(rd), .lq(data_in), .rq(rq));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // exp is {flag, granted}; granted judged on claims only
   task automatic hc(input op_e o, input logic [2:0] i, input logic [1:0] exp);
      @(negedge core_clk);
      while (cmd_ready !== 1'b1) @(negedge core_clk);
      cmd_valid = 1;
      cmd = '{o, i};
      @(negedge core_clk);
      cmd_valid = 0;
      for (int n = 0; n < 40 && res_valid !== 1'b1; n++) @(negedge core_clk);
      chk(16'({res_valid, res.flag, o == OP_CLAIM && res.granted}),
         16'({1'b1, exp}));
   endtask
   task automatic rw(input logic [2:0] i, input logic b);
      @(negedge core_clk);
      rp = '{1'b0, 1'b1, 1'b0, {12'hFFF, i}};
      rd = {15'h7FFF, b};
      repeat (3) @(negedge core_clk);
      rp = '1;
      rd = ~rd;
   endtask
   task automatic rr(input logic [2:0] i, input logic exp);
      @(negedge core_clk);
      rp = '{1'b0, 1'b0, 1'b1, {12'hFFF, i}};
      repeat (2) @(negedge core_clk);
      chk(rq, {16{exp}});
      rp = '1;
   endtask
   task automatic t_init;
      hc(OP_INIT, 3'h0, 2'b10);
      for (int i = 0; i < 8; i++) rw(3'(i), 1'b1);
      hc(OP_READ, 3'h7, 2'b10);
   endtask
   task automatic t_claim;
      hc(OP_CLAIM, 3'h2, 2'b01);
      rr(3'h2, 1'b1);
      rw(3'h2, 1'b0);
      rr(3'h2, 1'b1);
      hc(OP_READ, 3'h2, 2'b00);
      hc(OP_RELEASE, 3'h2, 2'b10);
      rr(3'h2, 1'b0);
   endtask
   task automatic t_pass;
      hc(OP_CLAIM, 3'h2, 2'b10);
      rw(3'h2, 1'b1);
      hc(OP_READ, 3'h2, 2'b00);
      hc(OP_RELEASE, 3'h2, 2'b10);
      rr(3'h2, 1'b1);
   endtask
   task automatic t_race;
      rw(3'h5, 1'b0);
      hc(OP_CLAIM, 3'h5, 2'b10);
      hc(OP_RELEASE, 3'h5, 2'b10);
      rw(3'h5, 1'b1);
      rr(3'h5, 1'b1);
      hc(OP_READ, 3'h5, 2'b10);
   endtask
   task conclude;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #50000;
      error_cnt++;
      conclude;
   end
   initial
   begin
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      reset = 0;
      t_init;
      t_claim;
      t_pass;
      t_race;
      conclude;
   end
endmodule
